// ===== rtl/asu_pkg.sv
package asu_pkg;

  // ************************************************
  // register map, byte addresses on the bus
  // ************************************************
  localparam logic [31:0] ADDR_CTL = 32'h0ffffa00;
  localparam logic [31:0] ADDR_STAT = 32'h0ffffa04;
  localparam logic [31:0] ADDR_RXB = 32'h0ffffa08;
  localparam logic [31:0] ADDR_TXB = 32'h0ffffa0c;

  // status field positions
  localparam int STAT_TSF = 7;
  localparam int STAT_PE = 2;
  localparam int STAT_FE = 1;
  localparam int STAT_OVE = 0;

  // reset values
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] RXB_RST = 8'hff;
  localparam logic [7:0] TXB_RST = 8'hff;
  localparam logic [8:0] CTL_RST = 9'h000;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************
  // timing: base clock cycles per serial bit
  // ************************************************
  localparam int CLK_NS = 20;
  localparam int BIT_NS = 320;
  localparam int CYC_PER_BIT = BIT_NS / CLK_NS;
  localparam logic [3:0] BIT_LAST = 4'(CYC_PER_BIT - 1);
  localparam logic [3:0] BIT_HALF = 4'(CYC_PER_BIT / 2 - 1);

  // control register layout, msb first: bit 8 down to bit 0
  typedef struct packed {
    logic brk;      // break-field reception mode
    logic pwr;      // unit_power_bit
    logic txe;      // transmit_enable_bit
    logic rxe;      // receive_enable_bit
    logic dir;      // 1 lsb first, 0 msb first
    logic [1:0] ps; // parity_select_high / parity_select_low
    logic cl;       // 1 eight-bit, 0 seven-bit characters
    logic sl;       // stop_length_bit
  } asu_ctl_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asu_rx_st_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } asu_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asu_axi_rsp_t;

endpackage

// ===== rtl/asu_serial.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - error flags clear on writing 0, writing 1 keeps them; transfer flag read-only
// - status reads zero after reset and while power bit is 0
// - transfer flag sets on transmit write, clears on disable or idle end
// - transfer flag stays 1 across back-to-back characters
// - parity error sets on parity mismatch, as parity select demands
// - error flags clear when power or receive enable is 0, or on 0 write
// - framing error checks only the first stop bit
// - overrun sets when a character completes while buffer is unread
// - on overrun the new character is discarded, old one kept
// - shift register copies into receive buffer at each completed character, unless buffer is unread or break mode is on
// - seven-bit lsb-first data sits in bits 6..0, bit 7 zero
// - seven-bit msb-first data sits in bits 7..1, bit 0 zero
// - receive buffer read-only, all ones on reset and power off
// - transmit buffer read-write, all ones after reset
// - two interrupts, receive-complete and transmit-enable, on separate outputs
// - receive-complete fires on buffer load only while reception enabled
// - transmit-enable fires when buffer moves into transmit shifter
// - status: transfer bit 7, parity 2, framing 1, overrun 0, rest zero
// - zero-parity reception performs no parity check
// - break-field reception suppresses errors and buffer transfer
module asu_serial (
  input wire logic aclk,
  input wire logic aresetn,
  input wire asu_pkg::asu_axi_req_t axi_req,
  output asu_pkg::asu_axi_rsp_t axi_rsp,
  input wire logic rxd,
  output logic txd,
  output logic receive_complete_irq,
  output logic transmit_enable_irq
);
  import asu_pkg::*;

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    asu_ctl_t ctl;
    logic tsf;
    logic pe;
    logic fe;
    logic ove;
    logic [7:0] rxb;
    logic rx_full;
    logic [7:0] txb;
    logic tx_pend;
    logic tx_busy;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_tick;
    asu_rx_st_t rx_st;
    logic [3:0] rx_tick;
    logic [3:0] rx_n;
    logic [9:0] rx_sh;
    logic rxd_q;
    logic aw_ok;
    logic w_ok;
    logic [31:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq_r;
    logic irq_t;
  } asu_state_t;

  asu_state_t s_reg;
  asu_state_t s_next;

  // bit order reversal
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction

  // ************************************************
  // bus handshakes
  // ************************************************
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_do;
  logic [7:0] stat_rd;

  // handshake outputs, combinational
  assign aw_take = axi_req.awvalid && !s_reg.aw_ok && !s_reg.bvalid;
  assign w_take = axi_req.wvalid && !s_reg.w_ok && !s_reg.bvalid;
  assign ar_take = axi_req.arvalid && !s_reg.rvalid;
  assign wr_do = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
  assign stat_rd = {s_reg.tsf, 4'h0, s_reg.pe, s_reg.fe, s_reg.ove};

  assign axi_rsp.awready = !s_reg.aw_ok && !s_reg.bvalid;
  assign axi_rsp.wready = !s_reg.w_ok && !s_reg.bvalid;
  assign axi_rsp.bvalid = s_reg.bvalid;
  assign axi_rsp.bresp = s_reg.bresp;
  assign axi_rsp.arready = !s_reg.rvalid;
  assign axi_rsp.rvalid = s_reg.rvalid;
  assign axi_rsp.rdata = s_reg.rdata;
  assign axi_rsp.rresp = s_reg.rresp;
  assign txd = s_reg.tx_sh[0];
  assign receive_complete_irq = s_reg.irq_r;
  assign transmit_enable_irq = s_reg.irq_t;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    logic [3:0] dlen;
    logic haspar;
    logic [7:0] src;
    logic [7:0] ord;
    logic [11:0] frm;
    logic [9:0] v;
    logic [7:0] dat;
    logic [3:0] need;
    logic parok;
    logic rx_clr;
    logic [2:0] err_set;
    dlen = s_reg.ctl.cl ? 4'h8 : 4'h7;
    haspar = s_reg.ctl.ps != 2'h0;
    src = '0;
    ord = '0;
    frm = '1;
    v = '0;
    dat = '0;
    need = dlen + {3'h0, haspar} + 4'h1;
    parok = 1'b1;
    rx_clr = 1'b0;
    err_set = '0;
    s_next = s_reg;
    s_next.irq_r = 1'b0;
    s_next.irq_t = 1'b0;
    s_next.rxd_q = rxd;

    // transmit shifter: one bit per CYC_PER_BIT cycles
    if (s_reg.tx_busy) begin
      s_next.tx_tick = s_reg.tx_tick + 4'h1;
      if (s_reg.tx_tick == BIT_LAST) begin
        s_next.tx_tick = '0;
        s_next.tx_sh = {1'b1, s_reg.tx_sh[11:1]};
        s_next.tx_left = s_reg.tx_left - 4'h1;
        if (s_reg.tx_left == 4'h1) begin
          s_next.tx_busy = 1'b0;
          if (!s_reg.tx_pend) begin
            s_next.tsf = 1'b0;
          end
        end
      end
    end else if (s_reg.tx_pend && s_reg.ctl.pwr && s_reg.ctl.txe) begin
      // buffer moves into shifter, frame built lsb out first
      src = s_reg.ctl.cl ? s_reg.txb : {s_reg.txb[6:0], 1'b0};
      ord = s_reg.ctl.dir ? s_reg.txb : rev8(src);
      frm[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (4'(i) < dlen) begin
          frm[i + 1] = ord[i];
        end
      end
      if (haspar) begin
        frm[dlen + 4'h1] = s_reg.ctl.ps[1] &
          (s_reg.ctl.ps[0] ~^ (^(s_reg.txb & {s_reg.ctl.cl, 7'h7f})));
      end
      s_next.tx_sh = frm;
      s_next.tx_left = need + 4'h1 + {3'h0, s_reg.ctl.sl};
      s_next.tx_tick = '0;
      s_next.tx_busy = 1'b1;
      s_next.tx_pend = 1'b0;
      s_next.irq_t = 1'b1;
    end

    // receiver: start check at half bit, then one sample per bit
    unique case (s_reg.rx_st)
      RX_IDLE: begin
        if (s_reg.ctl.pwr && s_reg.ctl.rxe && s_reg.rxd_q && !rxd) begin
          s_next.rx_st = RX_START;
          s_next.rx_tick = '0;
        end
      end
      RX_START: begin
        s_next.rx_tick = s_reg.rx_tick + 4'h1;
        if (s_reg.rx_tick == BIT_HALF) begin
          s_next.rx_tick = '0;
          s_next.rx_n = '0;
          s_next.rx_st = rxd ? RX_IDLE : RX_BITS;
        end
      end
      RX_BITS: begin
        s_next.rx_tick = s_reg.rx_tick + 4'h1;
        if (s_reg.rx_tick == BIT_LAST) begin
          s_next.rx_tick = '0;
          v = s_reg.rx_sh;
          v[s_reg.rx_n] = rxd;
          s_next.rx_sh = v;
          s_next.rx_n = s_reg.rx_n + 4'h1;
          if (s_reg.rx_n == need - 4'h1) begin
            s_next.rx_st = RX_IDLE;
            // 7-bit: lsb first into 6..0, msb first into 7..1
            dat = s_reg.ctl.cl ? v[7:0] : {1'b0, v[6:0]};
            if (!s_reg.ctl.dir) begin
              dat = rev8(dat);
            end
            // odd: ps0=0, even: ps0=1; zero parity not checked
            parok = !s_reg.ctl.ps[1] ||
              ((^(dat) ^ v[dlen]) == !s_reg.ctl.ps[0]);
            if (!s_reg.ctl.brk) begin
              // error events kept apart so that they beat a 0 write
              err_set = {!parok, !v[dlen + {3'h0, haspar}], s_reg.rx_full};
              if (!s_reg.rx_full) begin
                s_next.rxb = dat;
                s_next.rx_full = 1'b1;
                s_next.irq_r = 1'b1;
              end
            end
          end
        end
      end
    endcase
    s_next.pe = s_reg.pe | err_set[2];
    s_next.fe = s_reg.fe | err_set[1];
    s_next.ove = s_reg.ove | err_set[0];

    // bus capture
    if (aw_take) begin
      s_next.aw_ok = 1'b1;
      s_next.awaddr = axi_req.awaddr;
    end
    if (w_take) begin
      s_next.w_ok = 1'b1;
      s_next.wdata = axi_req.wdata;
      s_next.wstrb = axi_req.wstrb;
    end
    if (s_reg.bvalid && axi_req.bready) begin
      s_next.bvalid = 1'b0;
    end

    // register write, once both halves are in
    if (wr_do) begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      unique case (s_reg.awaddr)
        ADDR_CTL: begin
          if (s_reg.wstrb[0]) begin
            s_next.ctl[7:0] = s_reg.wdata[7:0];
          end
          if (s_reg.wstrb[1]) begin
            s_next.ctl[8] = s_reg.wdata[8];
          end
        end
        ADDR_STAT: begin
          if (s_reg.wstrb[0]) begin
            // zero clears, one keeps; hardware set below wins
            s_next.pe = (s_reg.pe & s_reg.wdata[STAT_PE]) | err_set[2];
            s_next.fe = (s_reg.fe & s_reg.wdata[STAT_FE]) | err_set[1];
            s_next.ove = (s_reg.ove & s_reg.wdata[STAT_OVE]) | err_set[0];
          end
        end
        ADDR_RXB: begin
          s_next.bresp = RESP_OKAY; // read-only, write ignored
        end
        ADDR_TXB: begin
          if (s_reg.wstrb[0]) begin
            s_next.txb = s_reg.wdata[7:0];
            s_next.tx_pend = 1'b1;
            s_next.tsf = 1'b1;
          end
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end

    // register read
    if (s_reg.rvalid && axi_req.rready) begin
      s_next.rvalid = 1'b0;
    end
    if (ar_take) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      unique case (axi_req.araddr)
        ADDR_CTL: s_next.rdata = {23'h0, s_reg.ctl};
        ADDR_STAT: s_next.rdata = {24'h0, stat_rd};
        ADDR_RXB: begin
          s_next.rdata = {24'h0, s_reg.rxb};
          s_next.rx_full = s_next.irq_r; // read frees buffer unless refilled now
        end
        ADDR_TXB: s_next.rdata = {24'h0, s_reg.txb};
        default: begin
          s_next.rdata = '0;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // enables act as resets
    if (!s_next.ctl.pwr || !s_next.ctl.txe) begin
      s_next.tsf = 1'b0;
      s_next.tx_busy = 1'b0;
      s_next.tx_pend = 1'b0;
      s_next.tx_sh = '1;
      s_next.irq_t = 1'b0;
    end
    rx_clr = !s_next.ctl.pwr || !s_next.ctl.rxe;
    if (rx_clr) begin
      s_next.pe = 1'b0;
      s_next.fe = 1'b0;
      s_next.ove = 1'b0;
      s_next.rx_st = RX_IDLE;
      s_next.irq_r = 1'b0;
    end
    if (!s_next.ctl.pwr) begin
      s_next.rxb = RXB_RST;
      s_next.rx_full = 1'b0;
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.ctl <= CTL_RST;
      s_reg.rxb <= RXB_RST;
      s_reg.txb <= TXB_RST;
      s_reg.tx_sh <= '1;
      s_reg.rxd_q <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic wr_tx;
  logic wr_stat;
  assign wr_tx = wr_do && s_reg.awaddr == ADDR_TXB && s_reg.wstrb[0];
  assign wr_stat = wr_do && s_reg.awaddr == ADDR_STAT && s_reg.wstrb[0];

  sequence s_tx_write_on;
    wr_tx && s_reg.ctl.pwr && s_reg.ctl.txe;
  endsequence

  sequence s_load_gap;
    !s_reg.tx_busy ##1 s_reg.tx_busy;
  endsequence

  chk_tsf_on_write: assert property (s_tx_write_on |=> s_reg.tsf)
    else $error("transfer flag not set by transmit write");
  chk_tsf_steady: assert property (s_reg.tsf && s_reg.tx_pend && s_reg.ctl.pwr &&
    s_reg.ctl.txe ##1 s_reg.ctl.pwr && s_reg.ctl.txe |-> s_reg.tsf)
    else $error("transfer flag dropped between characters");
  chk_status_off: assert property (!s_reg.ctl.pwr |-> stat_rd == STAT_RST)
    else $error("status not clear while powered off");
  chk_err_clear: assert property ($fell(s_reg.ctl.rxe) |-> !s_reg.pe && !s_reg.fe &&
    !s_reg.ove)
    else $error("error flags survived receive disable");
  chk_err_keep_one: assert property (wr_stat && s_reg.wdata[STAT_OVE] && s_reg.ove &&
    s_reg.ctl.rxe && s_next.ctl.pwr |=> s_reg.ove)
    else $error("overrun flag lost on write of one");
  chk_ove_keeps: assert property ($rose(s_reg.ove) && s_reg.ctl.pwr |->
    $stable(s_reg.rxb))
    else $error("overrun overwrote receive buffer");
  chk_rx_irq_gate: assert property (s_reg.irq_r |-> $past(s_reg.ctl.rxe) &&
    s_reg.rx_full)
    else $error("receive interrupt without enabled load");
  chk_rx_irq_pulse: assert property (s_reg.irq_r |=> !s_reg.irq_r)
    else $error("receive interrupt longer than one cycle");
  chk_tx_irq_load: assert property (s_load_gap |-> s_reg.irq_t && s_reg.tsf)
    else $error("transmit interrupt missing at shifter load");
  chk_rxb_power: assert property ($fell(s_reg.ctl.pwr) |-> s_reg.rxb == RXB_RST)
    else $error("receive buffer not all ones after power off");

endmodule

`default_nettype wire

// ===== verif/asu_node.sv
`timescale 1ns/1ps
`default_nettype none
module asu_node (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  import asu_pkg::*;

  // ************************************************
  // remote node: line idles high between frames
  // ************************************************
  initial rxd = 1'b1;

  // parity bit for odd, even and zero parity
  function automatic logic par_bit(input logic [8:0] c, input logic [7:0] ch);
    logic [7:0] d;
    d = c[1] ? ch : {1'b0, ch[6:0]};
    return (c[3:2] == 2'b10) ? ~^d : (c[3:2] == 2'b11) ? ^d : 1'b0;
  endfunction

  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (CYC_PER_BIT) @(posedge aclk);
  endtask

  // one frame; bp flips parity, bs breaks the first stop
  task automatic send_frame(input logic [8:0] c, input logic [7:0] ch, input logic bp,
                            input logic bs);
    int n;
    int i;
    n = c[1] ? 8 : 7;
    bit_out(1'b0);
    for (i = 0; i < n; i++) begin
      bit_out(c[4] ? ch[i] : ch[n-1-i]);
    end
    if (c[3:2] != 2'b00) begin
      bit_out(par_bit(c, ch) ^ bp);
    end
    bit_out(~bs);
    if (c[0]) begin
      bit_out(1'b1);
    end
    bit_out(1'b1);
  endtask

  // capture one frame from txd, sampling mid-bit
  task automatic get_frame(input logic [8:0] c, output logic [7:0] ch, output logic p,
                           output logic ok);
    int k;
    int i;
    ch = 8'h00;
    p = 1'b0;
    ok = 1'b0;
    for (k = 0; k < 4000 && txd; k++) @(posedge aclk);
    if (txd) return;
    repeat (CYC_PER_BIT / 2) @(posedge aclk);
    for (i = 0; i < (c[1] ? 8 : 7); i++) begin
      repeat (CYC_PER_BIT) @(posedge aclk);
      if (c[4]) ch[i] = txd;
      else ch = {ch[6:0], txd};
    end
    if (c[3:2] != 2'b00) begin
      repeat (CYC_PER_BIT) @(posedge aclk);
      p = txd;
    end
    repeat (CYC_PER_BIT) @(posedge aclk);
    ok = txd;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import asu_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  asu_axi_req_t req = '0;
  asu_axi_rsp_t rsp;
  logic rxd, txd, rx_irq, tx_irq;
  logic rx_q = 1'b0;
  logic tx_q = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  int seed = 32'hb5641416;
  logic [7:0] last_rx = 8'hff;
  logic [31:0] rd;
  logic [1:0] rs;

  asu_serial dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .rxd(rxd), .txd(txd), .receive_complete_irq(rx_irq), .transmit_enable_irq(tx_irq));
  asu_node node_u (.aclk(aclk), .txd(txd), .rxd(rxd));

  // ************************************************
  // clock, interrupt pulse monitor
  // ************************************************
  always #10 aclk = ~aclk;

  always @(posedge aclk) begin
    rx_q <= rx_irq;
    tx_q <= tx_irq;
    if (rx_irq === 1'b1) rx_cnt++;
    if (tx_irq === 1'b1) tx_cnt++;
    if ((rx_q && rx_irq) || (tx_q && tx_irq)) chk("irq_pulse", 34'h0, 34'h1);
  end

  // ************************************************
  // compare, report, bus tasks
  // ************************************************
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tmo;
    n_mismatch++;
    final_report();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    int k;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (!aw && rsp.awready) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid) begin
        rs = rsp.bresp;
        req.bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask

  task automatic rdr(input logic [31:0] a);
    logic ar;
    int k;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    ar = 1'b0;
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (ar && rsp.rvalid) begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        return;
      end
      if (!ar && rsp.arready) begin
        ar = 1'b1;
        req.arvalid <= 1'b0;
      end
    end
    tmo();
  endtask

  task automatic rc(input string nm, input logic [31:0] a, input logic [7:0] e);
    rdr(a);
    chk(nm, {RESP_OKAY, 24'h0, e}, {rs, rd});
  endtask

  // receive buffer image of a character for the given format
  function automatic logic [7:0] exp_rx(input logic [8:0] c, input logic [7:0] ch);
    return c[1] ? ch : (c[4] ? {1'b0, ch[6:0]} : {ch[6:0], 1'b0});
  endfunction

  // one received frame: irq count, buffer, status, clear by 0 write
  task automatic rx_case(input logic [8:0] c, input logic bp, input logic bs,
                         input logic rdb, input logic [7:0] est, input logic ld);
    logic [7:0] ch;
    int n0;
    ch = 8'($random(seed));
    wr(ADDR_CTL, 32'(c));
    n0 = rx_cnt;
    node_u.send_frame(c, ch, bp, bs);
    chk("rx_irq", 34'(ld), 34'(rx_cnt - n0));
    if (ld) last_rx = exp_rx(c, ch);
    if (rdb) begin
      rc("rx_buf", ADDR_RXB, last_rx);
      rc("status", ADDR_STAT, est);
      if (est != 8'h00) begin
        wr(ADDR_STAT, 32'hff);
        rc("status_keep", ADDR_STAT, est);
        wr(ADDR_STAT, 32'h0);
        rc("status_clr", ADDR_STAT, 8'h00);
      end
    end
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    logic [7:0] d [2];
    logic [7:0] ch;
    logic p;
    logic ok;
    int i;
    int j;
    int k;
    int n0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc("status_rst", ADDR_STAT, STAT_RST);
    rc("rx_rst", ADDR_RXB, RXB_RST);
    rc("tx_rst", ADDR_TXB, TXB_RST);
    rdr(32'h0ffffa10);
    chk("unmapped", {RESP_SLVERR, 32'h0}, {rs, rd});
    wr(32'h0ffffa10, 32'h5a);
    chk("unmapped_wr", 34'(RESP_SLVERR), 34'(rs));
    // every direction, parity, length and stop combination
    for (i = 0; i < 32; i++) begin
      rx_case(9'h0e0 | 9'(i), 1'b0, 1'b0, 1'b1, 8'h00, 1'b1);
    end
    rx_case(9'h0ea, 1'b1, 1'b0, 1'b1, 8'h04, 1'b1);
    rx_case(9'h0e6, 1'b1, 1'b0, 1'b1, 8'h00, 1'b1);
    rx_case(9'h0e3, 1'b0, 1'b1, 1'b1, 8'h02, 1'b1);
    rx_case(9'h0e2, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1);
    rx_case(9'h0e2, 1'b0, 1'b0, 1'b1, 8'h01, 1'b0);
    rx_case(9'h0c2, 1'b0, 1'b0, 1'b1, 8'h00, 1'b0);
    rx_case(9'h0ea, 1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
    wr(ADDR_CTL, 32'h0ca);
    rc("rxe_clr", ADDR_STAT, 8'h00);
    rx_case(9'h1ea, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0);
    wr(ADDR_RXB, 32'h55);
    chk("rx_wr_resp", 34'(RESP_OKAY), 34'(rs));
    rc("rx_ro", ADDR_RXB, last_rx);
    // back-to-back transmission, flag held through the gap
    wr(ADDR_CTL, 32'h0fe);
    d[0] = 8'($random(seed));
    d[1] = 8'($random(seed));
    n0 = tx_cnt;
    fork
      for (j = 0; j < 2; j++) begin
        node_u.get_frame(9'h0fe, ch, p, ok);
        chk("tx_char", 34'(d[j]), 34'(ch));
        chk("tx_frame", {32'h0, ^d[j], 1'b1}, {32'h0, p, ok});
      end
      begin
        wr(ADDR_TXB, 32'(d[0]));
        rc("tsf_set", ADDR_STAT, 8'h80);
        for (k = 0; k < 2000 && tx_cnt == n0; k++) @(posedge aclk);
        if (tx_cnt == n0) tmo();
        wr(ADDR_TXB, 32'(d[1]));
        rc("tx_buf", ADDR_TXB, d[1]);
        for (k = 0; k < 100 && tx_cnt < n0 + 2; k++) begin
          rc("tsf_hold", ADDR_STAT, 8'h80);
        end
        if (tx_cnt < n0 + 2) tmo();
      end
    join
    repeat (2 * CYC_PER_BIT) @(posedge aclk);
    rc("tsf_idle", ADDR_STAT, 8'h00);
    chk("tx_irq", 34'd2, 34'(tx_cnt - n0));
    wr(ADDR_TXB, 32'(d[0]));
    rc("tsf_busy", ADDR_STAT, 8'h80);
    wr(ADDR_CTL, 32'h0be);
    rc("tsf_txe_off", ADDR_STAT, 8'h00);
    wr(ADDR_CTL, 32'h0);
    rc("status_pwr", ADDR_STAT, 8'h00);
    rc("rx_pwr", ADDR_RXB, 8'hff);
    final_report();
  end
endmodule
`default_nettype wire
